//--- pkg/lsa_pkg.sv
// Purpose: Shared constants for the LED status and address strap block.
// Assumes: ref_clk at 50 MHz; AXI4-Lite register access, 32-bit data.
// Notes:   Every offset, field position, reset value and count is here.

package lsa_pkg;

   // ****************************************************************
   // Clock and timing.
   // ****************************************************************
   localparam int unsigned CLK_FREQ_KHZ    = 50000; // Clock rate in kHz.
   localparam int unsigned STRETCH_TIME_MS = 50;    // Blink time in ms.
   // Blink length in clock cycles, derived from the time and the rate.
   localparam int unsigned STRETCH_CYCLES  = STRETCH_TIME_MS * CLK_FREQ_KHZ;
   localparam int          CNT_W           = 22;    // Blink counter width.

   // ****************************************************************
   // Widths and pin positions.
   // ****************************************************************
   localparam int          ADDR_W   = 4;   // Register byte address width.
   localparam int          DATA_W   = 32;  // Register data width.
   localparam int          STRB_W   = 4;   // Byte strobe width.
   localparam int          STRAP_W  = 5;   // Number of shared strap pins.
   localparam int          PIN_DUPLEX = 0; // Full duplex indicator.
   localparam int          PIN_COLL   = 1; // Collision indicator.
   localparam int          PIN_LINK   = 2; // Good link indicator.
   localparam int          PIN_TX     = 3; // Transmit activity indicator.
   localparam int          PIN_RX     = 4; // Receive activity indicator.
   localparam logic [4:0]  PIN_ALL_ON  = 5'h1F; // All pins driven.
   localparam logic [4:0]  PIN_ALL_OFF = 5'h00; // All pins released.

   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam logic [3:0]  REG_CTRL   = 4'h0; // Physical-layer control.
   localparam logic [3:0]  REG_STATUS = 4'h4; // Indicator status.
   localparam int          CTRL_ADDR_LSB  = 0; // Management address field.
   localparam int          CTRL_ISO_BIT   = 5; // Isolate mode, read only.
   localparam int          CTRL_LEDEN_BIT = 8; // Indicator enable.
   localparam logic        LEDEN_RST      = 1'b1; // Indicators on at reset.
   localparam logic [4:0]  ISO_ADDR       = 5'h00; // Strap that isolates.
   localparam int          ST_LINK   = 0; // Status: link up.
   localparam int          ST_SPEED  = 1; // Status: 100 Mb/s.
   localparam int          ST_DUPLEX = 2; // Status: full duplex.
   localparam int          ST_COLL   = 3; // Status: collision.
   localparam int          ST_TX     = 4; // Status: stretched transmit.
   localparam int          ST_RX     = 5; // Status: stretched receive.
   localparam logic [1:0]  RESP_OKAY   = 2'h0; // Access accepted.
   localparam logic [1:0]  RESP_SLVERR = 2'h2; // Unmapped address.

endpackage

//--- hw/lsa_led_stretch.sv
// Purpose: Stretches a short activity pulse into a visible blink.
// Assumes: activity comes from logic on ref_clk.
// Notes:   A new event restarts the blink interval.

`timescale 1ns/100ps

module lsa_led_stretch
#(
   parameter int unsigned CYCLES = lsa_pkg::STRETCH_CYCLES
)
(
   input  wire logic ref_clk,   // System clock.
   input  wire logic resetn,    // Synchronous reset, active low.
   input  wire logic activity,  // Activity level from the core.
   output logic      lit        // Indicator should be on.
);
   import lsa_pkg::*;

   // ****************************************************************
   // Hold counter.
   // ****************************************************************
   logic [CNT_W-1:0] count_reg;  // Cycles of blink still to run.
   logic [CNT_W-1:0] count_next; // Next count.
   logic             lit_reg;    // Registered indicator state.
   logic             lit_next;   // Next indicator state.

   // Reloads on activity and counts down to zero afterwards.
   always_comb
   begin
      count_next = count_reg;
      if (activity)
      begin
         // Activity present: restart the whole interval.
         count_next = CNT_W'(CYCLES - 1);
      end
      else if (count_reg != '0)
      begin
         // Idle: let the blink run out.
         count_next = count_reg - CNT_W'(1);
      end
      lit_next = activity || (count_reg != '0);
   end

   // Registers the counter and the indicator state.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         count_reg <= '0;
         lit_reg   <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         lit_reg   <= lit_next;
      end
   end

   assign lit = lit_reg;

endmodule

//--- hw/lsa_led_strap.sv
// Purpose: Shared strap/indicator pins with AXI4-Lite control registers.
// Assumes: Status inputs come from core logic on ref_clk.
// Notes:   Hold resetn low for at least four edges so straps settle.
//
// How it works
// - Speed pin high at 100, low at 10.
// - Transmit indicator lit during transmit activity.
// - Receive indicator lit during receive activity.
// - Collision indicator shows half duplex collisions.
// - Duplex indicator shows full duplex mode.
// - Link indicator shows valid link.
// - Straps sampled in reset, latched to control.
// - Strapped address zero selects isolate mode.
// - Software address zero never selects isolation.
// - After reset, shared pins become indicator outputs.
// - Unstrapped pins read their pull level.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.

`timescale 1ns/100ps

module lsa_led_strap
#(
   parameter int unsigned STRETCH_CYCLES = lsa_pkg::STRETCH_CYCLES
)
(
   input  wire logic                        ref_clk,
   input  wire logic                        resetn,
   // Status from the transceiver core.
   input  wire logic                        linkUp,
   input  wire logic                        speed100,
   input  wire logic                        fullDuplex,
   input  wire logic                        collision,
   input  wire logic                        txActive,
   input  wire logic                        rxActive,
   // Shared strap and indicator pins.
   input  wire logic [lsa_pkg::STRAP_W-1:0] strapPinIn,
   output logic      [lsa_pkg::STRAP_W-1:0] ledPinOut,
   output logic      [lsa_pkg::STRAP_W-1:0] ledPinOe,
   output logic                             speedIndicator,
   output logic                             isolateMode,
   // AXI4-Lite slave.
   input  wire logic [lsa_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [lsa_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [lsa_pkg::STRB_W-1:0]  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic      [1:0]                  s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [lsa_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic      [lsa_pkg::DATA_W-1:0]  s_axi_rdata,
   output logic      [1:0]                  s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready
);
   import lsa_pkg::*;

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   logic [STRAP_W-1:0] strapMeta_reg;  // First synchroniser stage.
   logic [STRAP_W-1:0] strapSync_reg;  // Second synchroniser stage.
   logic [STRAP_W-1:0] ctrlAddr_reg;   // Management address field.
   logic [STRAP_W-1:0] ctrlAddr_next;
   logic               isolate_reg;    // Isolate mode from the strap.
   logic               isolate_next;
   logic               ledEn_reg;      // Indicator enable.
   logic               ledEn_next;
   logic               awHeld_reg;     // Write address captured.
   logic               awHeld_next;
   logic [ADDR_W-1:0]  awAddr_reg;     // Captured write address.
   logic [ADDR_W-1:0]  awAddr_next;
   logic               wHeld_reg;      // Write data captured.
   logic               wHeld_next;
   logic [DATA_W-1:0]  wData_reg;      // Captured write data.
   logic [DATA_W-1:0]  wData_next;
   logic [STRB_W-1:0]  wStrb_reg;      // Captured byte strobes.
   logic [STRB_W-1:0]  wStrb_next;
   logic               awReady_reg;
   logic               awReady_next;
   logic               wReady_reg;
   logic               wReady_next;
   logic               bValid_reg;
   logic               bValid_next;
   logic [1:0]         bResp_reg;
   logic [1:0]         bResp_next;
   logic               arReady_reg;
   logic               arReady_next;
   logic               rValid_reg;
   logic               rValid_next;
   logic [DATA_W-1:0]  rData_reg;
   logic [DATA_W-1:0]  rData_next;
   logic [1:0]         rResp_reg;
   logic [1:0]         rResp_next;
   logic [STRAP_W-1:0] pinOut_reg;     // Indicator levels.
   logic [STRAP_W-1:0] pinOut_next;
   logic [STRAP_W-1:0] pinOe_reg;      // Indicator drive enables.
   logic [STRAP_W-1:0] pinOe_next;
   logic               speed_reg;      // Speed indicator level.
   logic               speed_next;
   logic [1:0]         actIn;          // Transmit, receive activity.
   logic [1:0]         actLit;         // Stretched activity.

   // ****************************************************************
   // Strap synchroniser.
   // ****************************************************************
   // The pads resolve an unstrapped pin to its pull level.
   // Pull level sampled
   always_ff @(posedge ref_clk)
   begin
      strapMeta_reg <= strapPinIn;
      strapSync_reg <= strapMeta_reg;
   end

   // ****************************************************************
   // Control register and write channel.
   // ****************************************************************
   // Takes address and data in either order, then answers once.
   always_comb
   begin
      logic               awTake;
      logic               wTake;
      logic               commit;
      awTake        = s_axi_awvalid && awReady_reg;
      wTake         = s_axi_wvalid && wReady_reg;
      // Both halves present, now or from earlier, and no answer pending.
      commit        = (awHeld_reg || awTake) && (wHeld_reg || wTake)
                      && !bValid_reg;
      ctrlAddr_next = ctrlAddr_reg;
      ledEn_next    = ledEn_reg;
      awHeld_next   = awHeld_reg || awTake;
      wHeld_next    = wHeld_reg || wTake;
      awAddr_next   = awTake ? s_axi_awaddr : awAddr_reg;
      wData_next    = wTake ? s_axi_wdata : wData_reg;
      wStrb_next    = wTake ? s_axi_wstrb : wStrb_reg;
      bValid_next   = bValid_reg && !s_axi_bready;
      bResp_next    = bResp_reg;
      if (commit)
      begin
         // Both halves present: store and raise the response.
         awHeld_next = 1'b0;
         wHeld_next  = 1'b0;
         bValid_next = 1'b1;
         bResp_next  = RESP_OKAY;
         if (awAddr_next == REG_CTRL)
         begin
            if (wStrb_next[0])
            begin
               ctrlAddr_next = wData_next[CTRL_ADDR_LSB +: STRAP_W];
            end
            if (wStrb_next[CTRL_LEDEN_BIT / 8])
            begin
               ledEn_next = wData_next[CTRL_LEDEN_BIT];
            end
         end
         else if (awAddr_next != REG_STATUS)
         begin
            // Unmapped address: nothing stored.
            bResp_next = RESP_SLVERR;
         end
      end
      awReady_next = !awHeld_next && !bValid_next;
      wReady_next  = !wHeld_next && !bValid_next;
      // The isolate bit changes only under reset.
      isolate_next = isolate_reg;
   end

   // Registers the control group; straps are caught during reset.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         ctrlAddr_reg <= strapSync_reg;
         isolate_reg  <= (strapSync_reg == ISO_ADDR);
         ledEn_reg    <= LEDEN_RST;
         awHeld_reg   <= 1'b0;
         awAddr_reg   <= '0;
         wHeld_reg    <= 1'b0;
         wData_reg    <= '0;
         wStrb_reg    <= '0;
         awReady_reg  <= 1'b0;
         wReady_reg   <= 1'b0;
         bValid_reg   <= 1'b0;
         bResp_reg    <= RESP_OKAY;
      end
      else
      begin
         ctrlAddr_reg <= ctrlAddr_next;
         isolate_reg  <= isolate_next;
         ledEn_reg    <= ledEn_next;
         awHeld_reg   <= awHeld_next;
         awAddr_reg   <= awAddr_next;
         wHeld_reg    <= wHeld_next;
         wData_reg    <= wData_next;
         wStrb_reg    <= wStrb_next;
         awReady_reg  <= awReady_next;
         wReady_reg   <= wReady_next;
         bValid_reg   <= bValid_next;
         bResp_reg    <= bResp_next;
      end
   end

   // ****************************************************************
   // Read channel.
   // ****************************************************************
   // One read at a time; data is latched when the address is taken.
   always_comb
   begin
      rValid_next = rValid_reg && !s_axi_rready;
      rData_next  = rData_reg;
      rResp_next  = rResp_reg;
      if (s_axi_arvalid && arReady_reg)
      begin
         rValid_next = 1'b1;
         rData_next  = '0;
         rResp_next  = RESP_OKAY;
         if (s_axi_araddr == REG_CTRL)
         begin
            // Address, isolate and enable fields.
            rData_next[CTRL_ADDR_LSB +: STRAP_W] = ctrlAddr_reg;
            rData_next[CTRL_ISO_BIT]             = isolate_reg;
            rData_next[CTRL_LEDEN_BIT]           = ledEn_reg;
         end
         else if (s_axi_araddr == REG_STATUS)
         begin
            // Live status and stretched activity.
            rData_next[ST_LINK]   = linkUp;
            rData_next[ST_SPEED]  = speed100;
            rData_next[ST_DUPLEX] = fullDuplex;
            rData_next[ST_COLL]   = collision;
            rData_next[ST_TX]     = actLit[0];
            rData_next[ST_RX]     = actLit[1];
         end
         else
         begin
            // Unmapped address reads zero with an error.
            rResp_next = RESP_SLVERR;
         end
      end
      arReady_next = !rValid_next;
   end

   // Registers the read group.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         arReady_reg <= 1'b0;
         rValid_reg  <= 1'b0;
         rData_reg   <= '0;
         rResp_reg   <= RESP_OKAY;
      end
      else
      begin
         arReady_reg <= arReady_next;
         rValid_reg  <= rValid_next;
         rData_reg   <= rData_next;
         rResp_reg   <= rResp_next;
      end
   end

   // ****************************************************************
   // Activity stretchers.
   // ****************************************************************
   assign actIn = {rxActive, txActive};

   for (genvar i = 0; i < 2; i++)
   begin : g_stretch
      lsa_led_stretch
      #(
         .CYCLES   (STRETCH_CYCLES)
      )
      u_stretch
      (
         .ref_clk  (ref_clk),
         .resetn   (resetn),
         .activity (actIn[i]),
         .lit      (actLit[i])
      );
   end

   // ****************************************************************
   // Indicator pins.
   // ****************************************************************
   // Pins stay released in reset so the straps can be read.
   always_comb
   begin
      pinOut_next[PIN_DUPLEX] = ledEn_reg && fullDuplex;
      pinOut_next[PIN_COLL]   = ledEn_reg && collision && !fullDuplex;
      pinOut_next[PIN_LINK]   = ledEn_reg && linkUp;
      pinOut_next[PIN_TX]     = ledEn_reg && actLit[0];
      pinOut_next[PIN_RX]     = ledEn_reg && actLit[1];
      speed_next              = speed100;
      pinOe_next              = PIN_ALL_ON;
   end

   // Registers the pin group.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         pinOut_reg <= PIN_ALL_OFF;
         pinOe_reg  <= PIN_ALL_OFF;
         speed_reg  <= 1'b0;
      end
      else
      begin
         pinOut_reg <= pinOut_next;
         pinOe_reg  <= pinOe_next;
         speed_reg  <= speed_next;
      end
   end

   assign ledPinOut      = pinOut_reg;
   assign ledPinOe       = pinOe_reg;
   assign speedIndicator = speed_reg;
   assign isolateMode    = isolate_reg;
   assign s_axi_awready  = awReady_reg;
   assign s_axi_wready   = wReady_reg;
   assign s_axi_bvalid   = bValid_reg;
   assign s_axi_bresp    = bResp_reg;
   assign s_axi_arready  = arReady_reg;
   assign s_axi_rvalid   = rValid_reg;
   assign s_axi_rdata    = rData_reg;
   assign s_axi_rresp    = rResp_reg;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Activity with the indicators enabled for two cycles.
   // Activity seen while still in reset is never stretched, so it is
   // left out here.
   sequence txSeen;
      resetn && txActive && ledEn_reg ##1 ledEn_reg;
   endsequence
   sequence rxSeen;
      resetn && rxActive && ledEn_reg ##1 ledEn_reg;
   endsequence
   // End of a transmit burst with the indicators enabled.
   sequence txEnds;
      $fell(txActive) && $past(resetn) && ledEn_reg ##1 ledEn_reg [*3];
   endsequence

   // The pin registers hold their reset value one cycle past release,
   // so each follow check starts only from an edge out of reset.
   a_speed_follow: assert property
      (resetn |=> speedIndicator == $past(speed100))
      else $error("speed indicator does not follow the speed");
   a_tx_lit: assert property (txSeen |=> ledPinOut[PIN_TX])
      else $error("transmit indicator dark during activity");
   a_rx_lit: assert property (rxSeen |=> ledPinOut[PIN_RX])
      else $error("receive indicator dark during activity");
   a_coll_half: assert property
      ($past(fullDuplex) |-> !ledPinOut[PIN_COLL])
      else $error("collision shown in full duplex");
   a_duplex_show: assert property
      (resetn |=> ledPinOut[PIN_DUPLEX] == $past(fullDuplex && ledEn_reg))
      else $error("duplex indicator wrong");
   a_link_show: assert property
      (resetn |=> ledPinOut[PIN_LINK] == $past(linkUp && ledEn_reg))
      else $error("link indicator wrong");
   a_strap_latch: assert property
      ($rose(resetn) |-> ctrlAddr_reg == $past(strapSync_reg))
      else $error("strap address not latched");
   a_iso_strap: assert property
      ($rose(resetn) |-> isolateMode == (ctrlAddr_reg == ISO_ADDR))
      else $error("isolate does not match strap");
   a_iso_stable: assert property
      ($past(resetn) |-> $stable(isolateMode))
      else $error("isolate changed outside reset");
   a_pins_driven: assert property
      ($past(resetn) |-> ledPinOe == PIN_ALL_ON)
      else $error("indicator pins not driven");
   a_blink_hold: assert property (txEnds |-> ledPinOut[PIN_TX])
      else $error("transmit blink too short");

endmodule

//--- test/lsa_board_model.sv
// Purpose: Board strap resistors and pads on the shared indicator pins.
// Assumes: Every shared pin carries one external strap resistor.
// Notes:   A pad that the device drives shows the device level.

`timescale 1ns/100ps

module lsa_board_model
(
   input  wire logic [lsa_pkg::STRAP_W-1:0] strapValue,
   input  wire logic [lsa_pkg::STRAP_W-1:0] ledPinOut,
   input  wire logic [lsa_pkg::STRAP_W-1:0] ledPinOe,
   output logic      [lsa_pkg::STRAP_W-1:0] padLevel
);
   import lsa_pkg::*;
   always_comb
   begin
      for (int i = 0; i < STRAP_W; i++)
         padLevel[i] = ledPinOe[i] ? ledPinOut[i] : strapValue[i];
   end
endmodule

//--- test/lsa_led_strap_bench.sv
// Purpose: Self-checking bench for the strap and indicator block.
// Assumes: Blink length shortened to 8 cycles.
// Notes:   Bus master changes signals just after rising edges.

`timescale 1ns/100ps

module lsa_led_strap_bench;
   import lsa_pkg::*;
   localparam int unsigned STRETCH = 8; // Short blink for simulation.
   logic ref_clk, resetn, linkUp, speed100, fullDuplex, collision;
   logic txActive, rxActive, speedIndicator, isolateMode;
   logic [4:0] strapValue, strapPinIn, ledPinOut, ledPinOe;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] seed;
   int failures, tests_run, cycles;

   lsa_led_strap #(.STRETCH_CYCLES(STRETCH)) i_lsa_led_strap (.*);
   lsa_board_model i_lsa_board_model (.strapValue(strapValue),
      .ledPinOut(ledPinOut), .ledPinOe(ledPinOe), .padLevel(strapPinIn));

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   function logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   // Expected shared pins with activity quiet.
   function logic [4:0] expLeds(input logic en);
      return en ? {2'b00, linkUp, collision & ~fullDuplex, fullDuplex} : 5'h00;
   endfunction

   task check(input string what, input logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask

   task results;
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Write one word; address and data offered together.
   task axiWrite(input logic [3:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // Read one word; data and response taken at the rvalid edge.
   task axiRead(input logic [3:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Reset with the given strap level on the board.
   task doReset(input logic [4:0] s);
      @(posedge ref_clk);
      strapValue <= s;
      resetn <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("oe in reset", 32'h0, ledPinOe);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("oe after reset", 32'h1F, ledPinOe);
   endtask

   // ****************************************************************
   // Clock, timeout and main sequence.
   // ****************************************************************
   // Board reference clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         results();
      end
   end

   initial
   begin
      {resetn, linkUp, speed100, fullDuplex, collision} = 5'h00;
      {txActive, rxActive, s_axi_awvalid, s_axi_wvalid} = 4'h0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
      strapValue = 5'h13;
      seed = 8'h4F;
      doReset(5'h13);
      check("iso", 32'h0, isolateMode);
      axiRead(REG_CTRL);
      check("ctrl", 32'h113, rd);
      // Random line states, pins and status mirror them.
      repeat (12)
      begin
         seed = lfsr(seed);
         {linkUp, speed100, fullDuplex, collision} <= seed[3:0];
         repeat (3) @(posedge ref_clk);
         check("leds", expLeds(1'b1), ledPinOut);
         check("speed", speed100, speedIndicator);
         axiRead(REG_STATUS);
         check("stat", {collision, fullDuplex, speed100, linkUp}, rd);
      end
      // One-cycle activity blinks for the stretch time.
      for (int p = PIN_TX; p <= PIN_RX; p++)
      begin
         txActive <= (p == PIN_TX);
         rxActive <= (p == PIN_RX);
         @(posedge ref_clk);
         {txActive, rxActive} <= 2'b00;
         repeat (3) @(posedge ref_clk);
         check("blink on", 32'h1, ledPinOut[p]);
         repeat (5) @(posedge ref_clk);
         check("blink held", 32'h1, ledPinOut[p]);
         repeat (5) @(posedge ref_clk);
         check("blink off", 32'h0, ledPinOut[p]);
      end
      // Indicator enable off darkens the shared pins only.
      axiWrite(REG_CTRL, 32'h0, 4'h2);
      check("bresp", RESP_OKAY, rsp);
      {linkUp, speed100, collision, fullDuplex} <= 4'hE;
      repeat (3) @(posedge ref_clk);
      check("dark", 32'h0, ledPinOut);
      check("speed", 32'h1, speedIndicator);
      // Software address zero must not isolate.
      axiWrite(REG_CTRL, 32'h100, 4'h3);
      repeat (2) @(posedge ref_clk);
      check("iso sw", 32'h0, isolateMode);
      axiRead(REG_CTRL);
      check("ctrl sw", 32'h100, rd);
      // Unmapped places answer with an error.
      axiWrite(4'h8, 32'hFFFF_FFFF, 4'hF);
      check("bresp", RESP_SLVERR, rsp);
      axiRead(4'hC);
      check("rresp", RESP_SLVERR, rsp);
      check("rdata", 32'h0, rd);
      // Strap of zero at reset selects isolation.
      doReset(ISO_ADDR);
      check("iso hw", 32'h1, isolateMode);
      axiRead(REG_CTRL);
      check("ctrl iso", 32'h120, rd);
      results();
   end
endmodule
